// ==== design/ras_pkg.sv ====
// Constants and types shared by the return address stack.
package ras_pkg;

  // ****************************************************************
  // Geometry.
  // ****************************************************************
  localparam int PC_W    = 21;  // Program counter width.
  localparam int PTR_W   = 5;   // Stack pointer width.
  localparam int ENTRIES = 31;  // Storage entries behind pointers 1..31.
  localparam int ADDR_W  = 3;   // Register port address width.
  localparam int DATA_W  = 8;   // Register port data width.

  // Pointer values of note.
  localparam logic [PTR_W-1:0] PTR_EMPTY  = 5'h00;
  localparam logic [PTR_W-1:0] PTR_TOP    = 5'h1_F;
  localparam logic [PTR_W-1:0] PTR_NEARLY = 5'h1_E;
  localparam logic [PTR_W-1:0] PTR_ONE    = 5'h0_1;

  // ****************************************************************
  // Program counter constants.
  // ****************************************************************
  localparam logic [PC_W-1:0] RESET_VECTOR = 21'h00_0000;
  localparam logic [PC_W-1:0] HI_VECTOR    = 21'h00_0008;
  localparam logic [PC_W-1:0] LO_VECTOR    = 21'h00_0018;
  localparam logic [PC_W-1:0] PC_STEP      = 21'h00_0002;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_TOP_UPPER = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_TOP_HIGH  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_TOP_LOW   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_POINTER   = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 3'h5;

  // Field positions in the pointer register and the irq registers.
  localparam int BIT_FULL      = 7;
  localparam int BIT_UNDERFLOW = 6;
  localparam int IRQ_FULL      = 0;
  localparam int IRQ_UNDERFLOW = 1;

  // Reset values.
  localparam logic [1:0] IRQ_STAT_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // Whole state of the stack block, registered in one process.
  typedef struct packed {
    logic [ENTRIES-1:0][PC_W-1:0] mem;        // Stack storage.
    logic [PTR_W-1:0]             ptr;        // Stack pointer.
    logic                         full;       // Stack full flag.
    logic                         unf;        // Stack underflow flag.
    logic [1:0]                   irq_stat;   // Sticky event bits.
    logic [1:0]                   irq_mask;   // Interrupt enables.
    logic [PC_W-1:0]              pop_pc;     // Value returned by a pop.
    logic                         pop_valid;  // Pop answer strobe.
    logic                         ovf_req;    // Overflow reset request.
    logic [DATA_W-1:0]            rdata;      // Register read data.
  } ras_state_type;

endpackage

// ==== design/ras_return_stack.sv ====
// Return address stack with software pointer and top-entry registers.
//
// Contract
// - 31 entries of 21 bits, 5-bit pointer.
// - Every reset sets pointer zero; zero is empty.
// - Push, call, relative call, interrupt push the counter.
// - Push increments pointer, then writes the entry.
// - Returns read selected entry, then decrement pointer.
// - Returns leave the counter latch registers alone.
// - Three byte registers reach the selected entry.
// - Software reads and writes pointer 0 to 31.
// - Full flag sets after 31 pushes without pop.
// - Full flag clears only by software or power-on.
// - Overflow reset: store counter plus two, reset.
// - No overflow reset: pointer holds 31, overwrite.
// - Empty pop returns zero, sets underflow, pointer stays.
// - Underflow flag stays until software or power-on.
// - Storage only reachable via pointer and top registers.
// - Program counter is 21 bits wide.
// - Reset vector zero; empty pop lands there.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module ras_return_stack
  import ras_pkg::*;
(
  input  wire logic                         clk,        // Core clock.
  input  wire logic                         rst_n,      // Power-on reset.
  input  wire logic                         dev_reset,  // Other resets.
  input  wire logic                         ovf_rst_en, // Config bit.
  input  wire logic                         push,       // Push request.
  input  wire logic [ras_pkg::PC_W-1:0]     push_pc,    // Counter to save.
  input  wire logic                         pop,        // Pop request.
  output logic      [ras_pkg::PC_W-1:0]     pop_pc,     // Restored counter.
  output logic                              pop_valid,  // Pop answer.
  output logic                              ovf_reset,  // Device reset req.
  input  wire logic [ras_pkg::ADDR_W-1:0]   reg_addr,   // Register address.
  input  wire logic [ras_pkg::DATA_W-1:0]   reg_wdata,  // Write data.
  input  wire logic                         reg_wr,     // Write strobe.
  input  wire logic                         reg_rd,     // Read strobe.
  output logic      [ras_pkg::DATA_W-1:0]   reg_rdata,  // Read data.
  output logic                              irq         // Level interrupt.
);
  import ras_pkg::*;

  // ****************************************************************
  // State and helpers.
  // ****************************************************************
  // The whole stack, flags and bus answer live in one registered struct.
  ras_state_type    st_ff;
  ras_state_type    nxt_st;   // Next state.
  logic [PTR_W-1:0] top_idx;  // Storage index of the selected entry.
  logic [PC_W-1:0]  top_val;  // Selected entry, zero when empty.
  logic             full_evt; // Full event this cycle.
  logic             unf_evt;  // Underflow event this cycle.

  // Pointer n maps to storage slot n-1; pointer zero has no slot.
  // The same index and value feed the register reads and the pop path,
  // so software and the sequencer always see one top entry.
  always_comb begin
    top_idx = 5'(st_ff.ptr - PTR_ONE);
    top_val = RESET_VECTOR;
    if (st_ff.ptr != PTR_EMPTY) begin
      top_val = st_ff.mem[top_idx];
    end
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Software writes are applied first, then hardware stack operations
  // and events, so that a flag set in the cycle of its clear survives.
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.pop_valid = 1'b0;
    nxt_st.ovf_req   = 1'b0;
    nxt_st.rdata     = '0;
    full_evt         = 1'b0;
    unf_evt          = 1'b0;

    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_TOP_UPPER: begin
          // Upper byte holds only five counter bits.
          if (st_ff.ptr != PTR_EMPTY) begin
            nxt_st.mem[top_idx][20:16] = reg_wdata[4:0];
          end
        end
        OFS_TOP_HIGH: begin
          if (st_ff.ptr != PTR_EMPTY) begin
            nxt_st.mem[top_idx][15:8] = reg_wdata;
          end
        end
        OFS_TOP_LOW: begin
          if (st_ff.ptr != PTR_EMPTY) begin
            nxt_st.mem[top_idx][7:0] = reg_wdata;
          end
        end
        OFS_POINTER: begin
          // Writing zero to a flag clears it; one leaves it alone.
          nxt_st.ptr = reg_wdata[PTR_W-1:0];
          if (!reg_wdata[BIT_FULL]) begin
            nxt_st.full = 1'b0;
          end
          if (!reg_wdata[BIT_UNDERFLOW]) begin
            nxt_st.unf = 1'b0;
          end
        end
        OFS_IRQ_STAT: begin
          // Write one to clear.
          nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata[1:0];
        end
        OFS_IRQ_MASK: begin
          nxt_st.irq_mask = reg_wdata[1:0];
        end
        default: begin
          // Unmapped offsets ignore writes.
        end
      endcase
    end

    // Hardware stack operations. The sequencer never issues push and
    // pop together; push takes priority if it should.
    if (dev_reset) begin
      // Non power-on resets clear only the pointer, not the flags.
      nxt_st.ptr = PTR_EMPTY;
    end else if (push) begin
      if (st_ff.ptr == PTR_TOP) begin
        // Stack already full: overwrite the top entry in place.
        nxt_st.mem[ENTRIES-1] = push_pc;
        nxt_st.ptr            = PTR_TOP;
      end else if (st_ff.ptr == PTR_NEARLY) begin
        full_evt = 1'b1;
        if (ovf_rst_en) begin
          // Store the counter past the call, then reset the device.
          nxt_st.mem[ENTRIES-1] = 21'(push_pc + PC_STEP);
          nxt_st.ptr            = PTR_EMPTY;
          nxt_st.ovf_req        = 1'b1;
        end else begin
          nxt_st.mem[ENTRIES-1] = push_pc;
          nxt_st.ptr            = PTR_TOP;
        end
      end else begin
        // New pointer p+1 selects slot p.
        nxt_st.mem[st_ff.ptr] = push_pc;
        nxt_st.ptr            = 5'(st_ff.ptr + PTR_ONE);
      end
    end else if (pop) begin
      // Only the counter is restored; no counter latch is touched.
      nxt_st.pop_valid = 1'b1;
      if (st_ff.ptr == PTR_EMPTY) begin
        nxt_st.pop_pc = RESET_VECTOR;
        unf_evt       = 1'b1;
      end else begin
        nxt_st.pop_pc = top_val;
        nxt_st.ptr    = top_idx;
      end
    end

    // Events set flags after any clear so the set wins.
    if (full_evt) begin
      nxt_st.full               = 1'b1;
      nxt_st.irq_stat[IRQ_FULL] = 1'b1;
    end
    if (unf_evt) begin
      nxt_st.unf                     = 1'b1;
      nxt_st.irq_stat[IRQ_UNDERFLOW] = 1'b1;
    end

    // Register reads see the state before this cycle's updates.
    // A top-entry read at pointer zero returns zero: no slot stands there.
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_TOP_UPPER: nxt_st.rdata = {3'h0, top_val[20:16]};
        OFS_TOP_HIGH:  nxt_st.rdata = top_val[15:8];
        OFS_TOP_LOW:   nxt_st.rdata = top_val[7:0];
        OFS_POINTER: begin
          nxt_st.rdata = {st_ff.full, st_ff.unf, 1'b0, st_ff.ptr};
        end
        OFS_IRQ_STAT:  nxt_st.rdata = {6'h00, st_ff.irq_stat};
        OFS_IRQ_MASK:  nxt_st.rdata = {6'h00, st_ff.irq_mask};
        default:       nxt_st.rdata = '0;
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Power-on reset clears everything, flags included. The storage is
  // cleared too, which costs area but keeps reads defined.
  // Soft resets never reach this process; they only zero the pointer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.irq_stat <= IRQ_STAT_RST;
      st_ff.irq_mask <= IRQ_MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state flops; irq is the OR of the masked event bits.
  assign pop_pc    = st_ff.pop_pc;
  assign pop_valid = st_ff.pop_valid;
  assign ovf_reset = st_ff.ovf_req;
  assign reg_rdata = st_ff.rdata;
  assign irq       = |(st_ff.irq_stat & st_ff.irq_mask);

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // Every property below is held off while the power-on reset is low,
  // since the state is forced to zero then and nothing is sampled.
  // A soft reset empties the stack one edge later.
  property p_dev_reset_ptr;
    @(posedge clk) disable iff (!rst_n)
    dev_reset |=> st_ff.ptr == PTR_EMPTY;
  endproperty
  a_dev_reset_ptr: assert property (p_dev_reset_ptr)
    else $error("Pointer not zero after device reset.");

  // Normal push steps the pointer up by one and stores the counter.
  property p_push_inc;
    @(posedge clk) disable iff (!rst_n)
    (push && !dev_reset && st_ff.ptr < PTR_NEARLY) |=>
      (st_ff.ptr == 5'($past(st_ff.ptr) + 5'd1)) &&
      (st_ff.mem[$past(st_ff.ptr)] == $past(push_pc));
  endproperty
  a_push_inc: assert property (p_push_inc)
    else $error("Push did not increment pointer and store.");

  // Pop of a non-empty stack returns the entry and steps down.
  property p_pop_dec;
    @(posedge clk) disable iff (!rst_n)
    (pop && !push && !dev_reset && st_ff.ptr != PTR_EMPTY) |=>
      pop_valid && (pop_pc == $past(top_val)) &&
      (st_ff.ptr == 5'($past(st_ff.ptr) - 5'd1));
  endproperty
  a_pop_dec: assert property (p_pop_dec)
    else $error("Pop did not return top and decrement.");

  // Empty pop gives the reset vector and raises underflow.
  property p_underflow;
    @(posedge clk) disable iff (!rst_n)
    (pop && !push && !dev_reset && st_ff.ptr == PTR_EMPTY) |=>
      pop_valid && pop_pc == RESET_VECTOR && st_ff.unf &&
      st_ff.ptr == PTR_EMPTY;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("Empty pop handled wrongly.");

  // Full flag holds unless software writes zero to it.
  property p_full_sticky;
    @(posedge clk) disable iff (!rst_n)
    (st_ff.full && !(reg_wr && reg_addr == OFS_POINTER &&
      !reg_wdata[BIT_FULL])) |=> st_ff.full;
  endproperty
  a_full_sticky: assert property (p_full_sticky)
    else $error("Full flag dropped without software clear.");

  // Underflow flag holds unless software writes zero to it.
  property p_unf_sticky;
    @(posedge clk) disable iff (!rst_n)
    (st_ff.unf && !(reg_wr && reg_addr == OFS_POINTER &&
      !reg_wdata[BIT_UNDERFLOW])) |=> st_ff.unf;
  endproperty
  a_unf_sticky: assert property (p_unf_sticky)
    else $error("Underflow flag dropped without software clear.");

  // Thirty-first push with overflow reset enabled.
  property p_ovf_reset;
    @(posedge clk) disable iff (!rst_n)
    (push && !dev_reset && ovf_rst_en && st_ff.ptr == PTR_NEARLY) |=>
      ovf_reset && st_ff.full && st_ff.ptr == PTR_EMPTY &&
      st_ff.mem[ENTRIES-1] == 21'($past(push_pc) + PC_STEP) ##1 !ovf_reset;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset)
    else $error("Overflow reset sequence wrong.");

  // Without overflow reset the pointer parks at the top.
  property p_ovf_hold;
    @(posedge clk) disable iff (!rst_n)
    (push && !dev_reset && !ovf_rst_en && !reg_wr &&
      st_ff.ptr >= PTR_NEARLY) |=>
      st_ff.ptr == PTR_TOP && !ovf_reset &&
      st_ff.full == ($past(st_ff.full) || $past(st_ff.ptr) == PTR_NEARLY) &&
      st_ff.mem[ENTRIES-1] == $past(push_pc);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("Full stack push did not overwrite top.");

  // Pointer register reads back pointer and both flags.
  property p_ptr_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_POINTER) |=>
      reg_rdata == {$past(st_ff.full), $past(st_ff.unf), 1'b0,
                    $past(st_ff.ptr)};
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("Pointer register read back wrong.");

  // A pop answer only ever follows an accepted pop.
  property p_pop_answer_only;
    @(posedge clk) disable iff (!rst_n)
    (!pop || push || dev_reset) |=> !pop_valid;
  endproperty
  a_pop_answer_only: assert property (p_pop_answer_only)
    else $error("Pop answer without an accepted pop.");

  // The overflow reset request comes only from the thirty-first push.
  property p_ovf_only_full;
    @(posedge clk) disable iff (!rst_n)
    !(push && !dev_reset && ovf_rst_en && st_ff.ptr == PTR_NEARLY) |=>
      !ovf_reset;
  endproperty
  a_ovf_only_full: assert property (p_ovf_only_full)
    else $error("Overflow reset request without a full push.");

  // Device resets empty the stack but keep both flags.
  property p_dev_reset_flags;
    @(posedge clk) disable iff (!rst_n)
    (dev_reset && !reg_wr) |=>
      st_ff.full == $past(st_ff.full) && st_ff.unf == $past(st_ff.unf);
  endproperty
  a_dev_reset_flags: assert property (p_dev_reset_flags)
    else $error("Device reset changed a stack flag.");

  // The thirty-first push raises the full flag and its event bit.
  property p_full_event;
    @(posedge clk) disable iff (!rst_n)
    (push && !dev_reset && st_ff.ptr == PTR_NEARLY) |=>
      st_ff.full && st_ff.irq_stat[IRQ_FULL];
  endproperty
  a_full_event: assert property (p_full_event)
    else $error("Full push did not raise the full flag.");

  // A top-entry low byte write lands in the selected slot.
  property p_top_write_low;
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_TOP_LOW && st_ff.ptr != PTR_EMPTY &&
      !push && !pop && !dev_reset) |=>
      top_val[7:0] == $past(reg_wdata);
  endproperty
  a_top_write_low: assert property (p_top_write_low)
    else $error("Top entry low byte write lost.");

  // Top-entry reads show the selected slot as it stood.
  property p_top_read_low;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_TOP_LOW) |=>
      reg_rdata == $past(top_val[7:0]);
  endproperty
  a_top_read_low: assert property (p_top_read_low)
    else $error("Top entry low byte read back wrong.");

  // With the stack empty the top upper register reads as zero.
  property p_empty_top_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_TOP_UPPER && st_ff.ptr == PTR_EMPTY) |=>
      reg_rdata == 8'h00;
  endproperty
  a_empty_top_read: assert property (p_empty_top_read)
    else $error("Top register read nonzero on an empty stack.");

  // Read data stand for one cycle after a read and are zero otherwise.
  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data present without a read.");

endmodule

// ==== dv/ras_core_model.sv ====
// Behavioural model of the core sequencer that pushes and pops.
`timescale 1ns/1ps

module ras_core_model (
  input  wire logic                     clk,
  output logic                          push,
  output logic      [ras_pkg::PC_W-1:0] push_pc,
  output logic                          pop
);
  import ras_pkg::*;

  // The sequencer is idle out of reset.
  initial begin
    push    = 1'b0;
    push_pc = 21'h0_0000;
    pop     = 1'b0;
  end

  // A call, relative call, push or interrupt acknowledge saves the counter.
  // No push or pop is issued while the bench writes the top entry.
  task automatic do_push(input logic [PC_W-1:0] pc);
    @(posedge clk);
    push    <= 1'b1;
    push_pc <= pc;
    @(posedge clk);
    push    <= 1'b0;
    // The counter lines move on, so a stale value is never reused.
    push_pc <= ~pc;
    #1;
  endtask

  // A return of any kind asks for the saved counter back.
  task automatic do_pop();
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    #1;
  endtask
endmodule

// ==== dv/test_ras_return_stack.sv ====
// Self-checking testbench of the return address stack.
`timescale 1ns/1ps

module test_ras_return_stack;
  import ras_pkg::*;

  logic              clk, rst_n, dev_reset, ovf_rst_en, push, pop;
  logic              reg_wr, reg_rd, pop_valid, ovf_reset, irq;
  logic [PC_W-1:0]   push_pc, pop_pc;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  int                n_fail, check_count, cycles;
  logic [PC_W-1:0]   vals [3] = '{21'h1F_A5C3, 21'h00_0102, 21'h15_5AA9};

  ras_return_stack ras_return_stack_i (.clk(clk), .rst_n(rst_n),
    .dev_reset(dev_reset), .ovf_rst_en(ovf_rst_en), .push(push),
    .push_pc(push_pc), .pop(pop), .pop_pc(pop_pc), .pop_valid(pop_valid),
    .ovf_reset(ovf_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  ras_core_model ras_core_model_i (.clk(clk), .push(push),
    .push_pc(push_pc), .pop(pop));

  // ****************************************************************
  // Clock, timeout and shared tasks.
  // ****************************************************************
  always #2 clk = ~clk;

  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rchk(input string what, input logic [ADDR_W-1:0] a,
                      input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, {24'h0, reg_rdata}, {24'h0, exp});
  endtask

  task automatic popchk(input logic [PC_W-1:0] exp);
    ras_core_model_i.do_pop();
    chk("pop_valid", {31'h0, pop_valid}, 32'h1);
    chk("pop_pc", {11'h0, pop_pc}, {11'h0, exp});
    // The answer stands for one cycle only.
    @(posedge clk);
    #1;
    chk("pop_valid_low", {31'h0, pop_valid}, 32'h0);
  endtask

  task automatic pulse_dev_reset();
    @(posedge clk);
    dev_reset <= 1'b1;
    @(posedge clk);
    dev_reset <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    rchk("pointer", OFS_POINTER, 8'h00);
    rchk("irq_stat", OFS_IRQ_STAT, {6'h0, IRQ_STAT_RST});
    rchk("irq_mask", OFS_IRQ_MASK, {6'h0, IRQ_MASK_RST});
    rchk("unmapped", 3'h6, 8'h00);
    rchk("top_upper", OFS_TOP_UPPER, 8'h00);
    $display("test reset done");
  endtask

  // Three pushes, read the top bytes, then unwind in reverse order.
  task automatic t_lifo();
    for (int i = 0; i < 3; i++) ras_core_model_i.do_push(vals[i]);
    rchk("pointer", OFS_POINTER, 8'h03);
    rchk("top_upper", OFS_TOP_UPPER, {3'h0, vals[2][20:16]});
    rchk("top_high", OFS_TOP_HIGH, vals[2][15:8]);
    rchk("top_low", OFS_TOP_LOW, vals[2][7:0]);
    for (int i = 2; i >= 0; i--) popchk(vals[i]);
    rchk("pointer", OFS_POINTER, 8'h00);
    $display("test lifo done");
  endtask

  task automatic t_underflow();
    wr(OFS_IRQ_MASK, 8'h02);
    popchk(RESET_VECTOR);
    rchk("pointer", OFS_POINTER, 8'h40);
    chk("irq", {31'h0, irq}, 32'h1);
    ras_core_model_i.do_push(21'h00_0ABC);
    // A non power-on reset empties the stack but keeps the flag.
    pulse_dev_reset();
    rchk("pointer", OFS_POINTER, 8'h40);
    wr(OFS_IRQ_STAT, 8'h02);
    rchk("irq_stat", OFS_IRQ_STAT, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(OFS_POINTER, 8'h00);
    rchk("pointer", OFS_POINTER, 8'h00);
    $display("test underflow done");
  endtask

  // Without overflow reset the top entry is overwritten at pointer 31.
  task automatic t_wrap();
    // Overflow reset goes off here and back on in the next test.
    @(posedge clk);
    ovf_rst_en <= ~ovf_rst_en;
    wr(OFS_POINTER, 8'h1D);
    ras_core_model_i.do_push(21'h01_1111);
    ras_core_model_i.do_push(21'h02_2222);
    rchk("pointer", OFS_POINTER, 8'h9F);
    ras_core_model_i.do_push(21'h03_3333);
    rchk("pointer", OFS_POINTER, 8'h9F);
    popchk(21'h03_3333);
    rchk("pointer", OFS_POINTER, 8'h9E);
    // The full event is recorded but its interrupt is masked.
    rchk("irq_stat", OFS_IRQ_STAT, 8'h01);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_STAT, 8'h01);
    wr(OFS_POINTER, 8'h00);
    $display("test wrap done");
  endtask

  // Thirty-one real pushes with overflow reset enabled.
  task automatic t_overflow();
    @(posedge clk);
    ovf_rst_en <= ~ovf_rst_en;
    for (int i = 1; i <= 30; i++) ras_core_model_i.do_push(PC_W'(i));
    rchk("pointer", OFS_POINTER, 8'h1E);
    ras_core_model_i.do_push(21'h0A_BCDE);
    chk("ovf_reset", {31'h0, ovf_reset}, 32'h1);
    @(posedge clk);
    #1;
    chk("ovf_reset_low", {31'h0, ovf_reset}, 32'h0);
    rchk("pointer", OFS_POINTER, 8'h80);
    pulse_dev_reset();
    rchk("pointer", OFS_POINTER, 8'h80);
    wr(OFS_POINTER, 8'h9F);
    rchk("top_upper", OFS_TOP_UPPER, 8'h0A);
    rchk("top_low", OFS_TOP_LOW, 8'hE0);
    wr(OFS_POINTER, 8'h00);
    rchk("pointer", OFS_POINTER, 8'h00);
    $display("test overflow done");
  endtask

  // A power-on reset in mid-run clears what soft resets keep.
  task automatic t_power_on();
    wr(OFS_POINTER, 8'h1E);
    ras_core_model_i.do_push(21'h00_0100);
    rchk("pointer", OFS_POINTER, 8'h80);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk("pointer", OFS_POINTER, 8'h00);
    rchk("irq_stat", OFS_IRQ_STAT, {6'h0, IRQ_STAT_RST});
    $display("test power on done");
  endtask

  // Software replaces the saved counter before the return.
  task automatic t_top_write();
    ras_core_model_i.do_push(21'h00_0001);
    wr(OFS_TOP_UPPER, 8'h13);
    wr(OFS_TOP_HIGH, 8'h57);
    wr(OFS_TOP_LOW, 8'h9B);
    popchk(21'h13_579B);
    $display("test top write done");
  endtask

  initial begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    dev_reset  = 1'b0;
    ovf_rst_en = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 3'h0;
    reg_wdata  = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_lifo();
    t_underflow();
    t_wrap();
    t_overflow();
    t_power_on();
    t_top_write();
    tally_and_finish();
  end
endmodule
